// ===== design/signed_mac_long_dual_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_datapath_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - long form: 32x32 product plus register pair
// - first halfword chosen by high-select bit
// - second halfword chosen by high-select bit
// - halfword product sign-extended before long add
// - 64-bit sums wrap, no overflow detection
// - long dual adds both halfword products
// - swap rotates second source by sixteen
// - word-by-halfword keeps bits 47:16 only
// - word-by-halfword overflow sets sticky flag
// - in the 32-bit forms, accumulate field all ones means no accumulate
// - dual subtract: low minus high plus accumulate
// - 32-bit overflow sets flag, only reset clears it
// - long dual subtract accumulates product difference
// - long subtract result split into pair words
module signed_mac_long_dual_datapath
	import mac_datapath_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic VALID_IN,
	input wire logic COND_PASS_IN,
	input wire op_e OP_IN,
	input wire logic FIRST_HIGH_IN,
	input wire logic SECOND_HIGH_IN,
	input wire logic SWAP_IN,
	input wire logic [3:0] ACC_FIELD_IN,
	input wire logic [`MAC_WORD_W-1:0] FIRST_SRC_IN,
	input wire logic [`MAC_WORD_W-1:0] SECOND_SRC_IN,
	input wire logic [`MAC_WORD_W-1:0] ACC_SRC_IN,
	input wire logic [`MAC_WORD_W-1:0] ACC_HI_IN,
	input wire logic [`MAC_WORD_W-1:0] ACC_LO_IN,
	output logic DONE_OUT,
	output logic WR_HIGH_OUT,
	output logic WR_LOW_OUT,
	output logic [`MAC_WORD_W-1:0] HIGH_DEST_OUT,
	output logic [`MAC_WORD_W-1:0] LOW_DEST_OUT,
	output logic SAT_FLAG_OUT
);

	//////////////////////////////////////////////////////////////////////////
	// operand selection

	logic signed [`MAC_WORD_W-1:0] first_word; // first source as signed
	logic signed [`MAC_WORD_W-1:0] second_word; // second source as signed
	logic [`MAC_WORD_W-1:0] second_rot; // second source after optional swap
	logic signed [`MAC_HALF_W-1:0] first_half; // selected first halfword
	logic signed [`MAC_HALF_W-1:0] second_half; // selected second halfword
	logic acc_none; // field all ones: accumulate dropped
	logic signed [`MAC_WORD_W-1:0] acc_word; // 32-bit accumulate value
	logic signed [`MAC_LONG_W-1:0] acc_pair; // high:low pair accumulate

	assign first_word = FIRST_SRC_IN;
	assign second_word = SECOND_SRC_IN;
	// swap the halves of the second source for the dual forms
	assign second_rot = SWAP_IN ? {SECOND_SRC_IN[`MAC_HALF_MSB:0],
		SECOND_SRC_IN[`MAC_WORD_MSB:`MAC_HALF_LSB]} : SECOND_SRC_IN;
	// halfword picks, top half when the select bit is set
	assign first_half = FIRST_HIGH_IN ? FIRST_SRC_IN[`MAC_WORD_MSB:`MAC_HALF_LSB]
		: FIRST_SRC_IN[`MAC_HALF_MSB:0];
	assign second_half = SECOND_HIGH_IN ? SECOND_SRC_IN[`MAC_WORD_MSB:`MAC_HALF_LSB]
		: SECOND_SRC_IN[`MAC_HALF_MSB:0];
	// the non-accumulating multiplies share this path with a zero addend
	assign acc_none = (ACC_FIELD_IN == `MAC_ACC_NONE);
	assign acc_word = acc_none ? `MAC_RST_WORD : ACC_SRC_IN;
	assign acc_pair = {ACC_HI_IN, ACC_LO_IN};

	//////////////////////////////////////////////////////////////////////////
	// products

	logic signed [`MAC_LONG_W-1:0] prod_long; // full 32x32 product
	logic signed [`MAC_WORD_W-1:0] prod_half; // selected 16x16 product
	logic signed [`MAC_WH_PROD_W-1:0] prod_wh; // 32x16 product
	logic signed [`MAC_WORD_W-1:0] prod_lo; // bottom lane product
	logic signed [`MAC_WORD_W-1:0] prod_hi; // top lane product

	assign prod_long = first_word * second_word;
	assign prod_half = first_half * second_half;
	assign prod_wh = first_word * second_half;

	// both halfword lanes of the dual forms
	dual_halfword_multiplier u_dual (
		.first_in(FIRST_SRC_IN),
		.second_in(second_rot),
		.low_product_out(prod_lo),
		.high_product_out(prod_hi)
	);

	//////////////////////////////////////////////////////////////////////////
	// sums

	logic signed [`MAC_LONG_W-1:0] sum_long_mac; // 32x32 plus pair
	logic signed [`MAC_LONG_W-1:0] sum_long_half; // halfword product plus pair
	logic signed [`MAC_LONG_W-1:0] sum_long_dual; // both lanes plus pair
	logic signed [`MAC_LONG_W-1:0] sum_long_sub; // lane difference plus pair
	logic signed [`MAC_LONG_W-1:0] sum_long; // chosen long result
	logic signed [`MAC_WH_FULL_W-1:0] wh_full; // exact word-by-halfword sum
	logic signed [`MAC_DS_FULL_W-1:0] ds_full; // exact dual subtract sum
	logic wh_sat; // word-by-halfword result does not fit
	logic ds_sat; // dual subtract result does not fit

	// 64-bit sums keep only the low 64 bits, so they wrap silently
	assign sum_long_mac = prod_long + acc_pair;
	assign sum_long_half = prod_half + acc_pair;
	assign sum_long_dual = prod_lo + prod_hi + acc_pair;
	assign sum_long_sub = prod_lo - prod_hi + acc_pair;

	// pick the long result for the decoded operation
	assign sum_long = (OP_IN == OP_LONG_MAC) ? sum_long_mac
		: (OP_IN == OP_LONG_HALF_MAC) ? sum_long_half
		: (OP_IN == OP_LONG_DUAL_MAC) ? sum_long_dual
		: sum_long_sub;

	// accumulate is aligned at bit 16 so bits 47:16 form the result
	assign wh_full = prod_wh + (acc_word <<< `MAC_HALF_LSB);
	// the top two bits disagree when the kept word loses the sign
	assign wh_sat = wh_full[`MAC_WH_SIGN] != wh_full[`MAC_WH_KEEP_MSB];

	assign ds_full = prod_lo - prod_hi + acc_word;
	// exact result differs from the sign extension of its low word
	assign ds_sat = (ds_full[`MAC_DS_SIGN] != ds_full[`MAC_WORD_MSB])
		|| (ds_full[`MAC_DS_GUARD] != ds_full[`MAC_WORD_MSB]);

	//////////////////////////////////////////////////////////////////////////
	// next values

	logic is_long; // operation writes the register pair
	logic fire; // instruction issued and its condition passed
	logic next_done;
	logic next_wr_high;
	logic next_wr_low;
	logic [`MAC_WORD_W-1:0] next_high;
	logic [`MAC_WORD_W-1:0] next_low;
	logic next_sat;

	assign is_long = (OP_IN == OP_LONG_MAC) || (OP_IN == OP_LONG_HALF_MAC)
		|| (OP_IN == OP_LONG_DUAL_MAC) || (OP_IN == OP_LONG_DUAL_SUB);
	assign fire = VALID_IN && COND_PASS_IN;
	assign next_done = VALID_IN;
	assign next_wr_high = fire && is_long;
	assign next_wr_low = fire;
	assign next_high = is_long ? sum_long[`MAC_LONG_MSB:`MAC_LONG_HI_LSB]
		: `MAC_RST_WORD;
	// word forms return the kept window or the low 32 bits
	assign next_low = is_long ? sum_long[`MAC_WORD_MSB:0]
		: (OP_IN == OP_WORD_HALF_MAC) ? wh_full[`MAC_WH_KEEP_MSB:`MAC_HALF_LSB]
		: ds_full[`MAC_WORD_MSB:0];
	// sticky: only 32-bit forms set it, only reset clears it
	assign next_sat = SAT_FLAG_OUT || (fire && !is_long
		&& ((OP_IN == OP_WORD_HALF_MAC) ? wh_sat : ds_sat));

	//////////////////////////////////////////////////////////////////////////
	// output registers, frozen while the clock enable is low

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			DONE_OUT <= `MAC_RST_BIT;
			WR_HIGH_OUT <= `MAC_RST_BIT;
			WR_LOW_OUT <= `MAC_RST_BIT;
			HIGH_DEST_OUT <= `MAC_RST_WORD;
			LOW_DEST_OUT <= `MAC_RST_WORD;
			SAT_FLAG_OUT <= `MAC_RST_BIT;
		end else if (CE_IN) begin
			DONE_OUT <= next_done;
			WR_HIGH_OUT <= next_wr_high;
			WR_LOW_OUT <= next_wr_low;
			HIGH_DEST_OUT <= next_high;
			LOW_DEST_OUT <= next_low;
			SAT_FLAG_OUT <= next_sat;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	logic take; // an issued instruction is captured this edge
	assign take = CE_IN && fire;

	a_long_mac_sum: assert property (take && OP_IN == OP_LONG_MAC |=>
		$signed({HIGH_DEST_OUT, LOW_DEST_OUT}) == $signed($past(FIRST_SRC_IN))
		* $signed($past(SECOND_SRC_IN)) + $signed({$past(ACC_HI_IN), $past(ACC_LO_IN)}))
		else $error("long mac result wrong");

	a_long_half_sum: assert property (take && OP_IN == OP_LONG_HALF_MAC |=>
		$signed({HIGH_DEST_OUT, LOW_DEST_OUT}) == $signed($past(prod_half))
		+ $signed({$past(ACC_HI_IN), $past(ACC_LO_IN)}))
		else $error("long halfword mac result wrong");

	a_half_select: assert property (take && FIRST_HIGH_IN && !SECOND_HIGH_IN |->
		prod_half == $signed(FIRST_SRC_IN[`MAC_WORD_MSB:`MAC_HALF_LSB])
		* $signed(SECOND_SRC_IN[`MAC_HALF_MSB:0]))
		else $error("halfword select wrong");

	a_long_dual_sum: assert property (take && OP_IN == OP_LONG_DUAL_MAC |=>
		$signed({HIGH_DEST_OUT, LOW_DEST_OUT}) == $signed($past(prod_lo))
		+ $signed($past(prod_hi)) + $signed({$past(ACC_HI_IN), $past(ACC_LO_IN)}))
		else $error("long dual mac result wrong");

	a_swap_lanes: assert property (SWAP_IN |->
		prod_lo == $signed(FIRST_SRC_IN[`MAC_HALF_MSB:0])
		* $signed(SECOND_SRC_IN[`MAC_WORD_MSB:`MAC_HALF_LSB]))
		else $error("swap did not cross halves");

	a_long_sub_sum: assert property (take && OP_IN == OP_LONG_DUAL_SUB |=>
		$signed({HIGH_DEST_OUT, LOW_DEST_OUT}) == $signed($past(prod_lo))
		- $signed($past(prod_hi)) + $signed({$past(ACC_HI_IN), $past(ACC_LO_IN)}))
		else $error("long dual subtract result wrong");

	// the kept window always goes out; a window unequal to the full sum needs the flag
	a_wh_window: assert property (take && OP_IN == OP_WORD_HALF_MAC |=>
		LOW_DEST_OUT == 32'($past(wh_full) >>> `MAC_HALF_LSB)
		&& (SAT_FLAG_OUT || $signed(LOW_DEST_OUT) == ($past(wh_full) >>> `MAC_HALF_LSB)))
		else $error("word by halfword result wrong");

	a_ds_word: assert property (take && OP_IN == OP_DUAL_SUB && !acc_none |=>
		LOW_DEST_OUT == 32'($signed($past(prod_lo)) - $signed($past(prod_hi))
		+ $signed($past(ACC_SRC_IN))))
		else $error("dual subtract result wrong");

	a_sat_sticky: assert property ($rose(SAT_FLAG_OUT) |->
		SAT_FLAG_OUT [*8])
		else $error("sticky flag cleared");

	a_sat_cause: assert property ($rose(SAT_FLAG_OUT) |->
		$past(take) && !$past(is_long) && ($past(wh_sat) || $past(ds_sat)))
		else $error("sticky flag set without overflow");

	a_cond_fail: assert property (CE_IN && VALID_IN && !COND_PASS_IN |=>
		!WR_HIGH_OUT && !WR_LOW_OUT && DONE_OUT && $stable(SAT_FLAG_OUT))
		else $error("failed condition changed state");

	a_long_no_sat: assert property (CE_IN && is_long |=>
		$stable(SAT_FLAG_OUT))
		else $error("long form touched sticky flag");

	c_long_mac: cover property (take && OP_IN == OP_LONG_MAC ##1 WR_HIGH_OUT);
	c_wh_overflow: cover property (take && OP_IN == OP_WORD_HALF_MAC && wh_sat);
	c_ds_overflow: cover property (take && OP_IN == OP_DUAL_SUB && ds_sat);
	c_swap_sub: cover property (take && SWAP_IN && OP_IN == OP_LONG_DUAL_SUB);

endmodule
`default_nettype wire

// ===== design/mac_datapath_regs.svh
`ifndef MAC_DATAPATH_REGS_SVH
`define MAC_DATAPATH_REGS_SVH

// operand and result widths
`define MAC_HALF_W 16
`define MAC_WORD_W 32
`define MAC_WH_PROD_W 48
`define MAC_WH_FULL_W 49
`define MAC_DS_FULL_W 34
`define MAC_LONG_W 64

// bit positions inside words and results
`define MAC_HALF_MSB 15
`define MAC_HALF_LSB 16
`define MAC_WORD_MSB 31
`define MAC_LONG_MSB 63
`define MAC_LONG_HI_LSB 32
`define MAC_WH_KEEP_MSB 47
`define MAC_WH_SIGN 48
`define MAC_DS_SIGN 33
`define MAC_DS_GUARD 32

// halfword lane count of the dual multiplier
`define MAC_LANES 2

// accumulate register field meaning "no accumulate"
`define MAC_ACC_NONE 4'hf

// reset values
`define MAC_RST_WORD 32'h0000_0000
`define MAC_RST_BIT 1'h0

`endif

// ===== design/mac_datapath_pkg.sv
package mac_datapath_pkg;

	// operation selected by the instruction decoder
	typedef enum logic [2:0] {
		OP_LONG_MAC,
		OP_LONG_HALF_MAC,
		OP_LONG_DUAL_MAC,
		OP_LONG_DUAL_SUB,
		OP_WORD_HALF_MAC,
		OP_DUAL_SUB
	} op_e;

endpackage

// ===== design/dual_halfword_multiplier.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_datapath_regs.svh"

module dual_halfword_multiplier (
	input wire logic [`MAC_WORD_W-1:0] first_in,
	input wire logic [`MAC_WORD_W-1:0] second_in,
	output logic signed [`MAC_WORD_W-1:0] low_product_out,
	output logic signed [`MAC_WORD_W-1:0] high_product_out
);

	// one signed 16x16 product per halfword lane
	logic signed [`MAC_WORD_W-1:0] lane_product [`MAC_LANES];

	// lane 0 multiplies bottom halves, lane 1 top halves
	for (genvar lane = 0; lane < `MAC_LANES; lane++) begin : g_lane
		logic signed [`MAC_HALF_W-1:0] a_half;
		logic signed [`MAC_HALF_W-1:0] b_half;
		assign a_half = first_in[lane*`MAC_HALF_W +: `MAC_HALF_W];
		assign b_half = second_in[lane*`MAC_HALF_W +: `MAC_HALF_W];
		assign lane_product[lane] = a_half * b_half;
	end

	assign low_product_out = lane_product[0];
	assign high_product_out = lane_product[1];

endmodule
`default_nettype wire

// ===== sim/operand_source_model.sv
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// decoder and register file side: hands legal register choices to the datapath
module operand_source_model (
	input wire logic [3:0] raw_field_in, // field drawn by the bench
	input wire logic [31:0] pair_a_in, // first register of the pair
	input wire logic [31:0] pair_b_in, // second, distinct register
	output logic [3:0] acc_field_out, // legal accumulate field
	output logic [31:0] acc_hi_out, // high accumulate word
	output logic [31:0] acc_lo_out // low accumulate word
);
	// stack pointer number is never picked, moved one register down
	assign acc_field_out = (raw_field_in == 4'hd) ? 4'hc : raw_field_in;
	// pair read from two separate registers, never one register twice
	assign acc_hi_out = pair_a_in;
	assign acc_lo_out = pair_b_in;
endmodule

`default_nettype wire

// ===== sim/tb_signed_mac_long_dual_datapath.sv
`timescale 1ns/1ps
`default_nettype none

module tb_signed_mac_long_dual_datapath
	import mac_datapath_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, valid = 1'b0, cond = 1'b0;
	logic fh = 1'b0, sh = 1'b0, swap = 1'b0, done, wr_hi, wr_lo, sat;
	op_e op = OP_LONG_MAC;
	logic [3:0] raw_field = 4'h0, acc_field;
	logic [31:0] f = 32'h0, s = 32'h0, acc = 32'h0, pa = 32'h0, pb = 32'h0;
	logic [31:0] hi, lo, hi_out, lo_out, exp_hi, exp_lo, lfsr = 32'hdab740d5;
	logic sat_model = 1'b0, exp_set, is_long;
	int bad_count = 0, total_checks = 0;

	//////////////////////////////////////////////////////////////////////////
	// clock, far side model and design
	always #4 clk = ~clk;
	operand_source_model i_src (.raw_field_in(raw_field), .pair_a_in(pa), .pair_b_in(pb),
		.acc_field_out(acc_field), .acc_hi_out(hi), .acc_lo_out(lo));
	signed_mac_long_dual_datapath i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
		.VALID_IN(valid), .COND_PASS_IN(cond), .OP_IN(op), .FIRST_HIGH_IN(fh),
		.SECOND_HIGH_IN(sh), .SWAP_IN(swap), .ACC_FIELD_IN(acc_field), .FIRST_SRC_IN(f),
		.SECOND_SRC_IN(s), .ACC_SRC_IN(acc), .ACC_HI_IN(hi), .ACC_LO_IN(lo),
		.DONE_OUT(done), .WR_HIGH_OUT(wr_hi), .WR_LOW_OUT(wr_lo), .HIGH_DEST_OUT(hi_out),
		.LOW_DEST_OUT(lo_out), .SAT_FLAG_OUT(sat));

	//////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	// reference arithmetic from the inputs now driven
	function automatic void predict();
		longint a64, r, p1, p2, av;
		logic [31:0] s2;
		logic [15:0] h1, h2;
		// taken from the bench's own pair values, the model's nets settle later
		a64 = {pa, pb};
		h1 = fh ? f[31:16] : f[15:0];
		h2 = sh ? s[31:16] : s[15:0];
		s2 = swap ? {s[15:0], s[31:16]} : s;
		p1 = longint'($signed(f[15:0])) * longint'($signed(s2[15:0]));
		p2 = longint'($signed(f[31:16])) * longint'($signed(s2[31:16]));
		av = (raw_field == 4'hf) ? 64'sh0 : longint'($signed(acc));
		exp_set = 1'b0;
		is_long = op inside {OP_LONG_MAC, OP_LONG_HALF_MAC, OP_LONG_DUAL_MAC, OP_LONG_DUAL_SUB};
		case (op)
			OP_LONG_MAC: r = longint'($signed(f)) * longint'($signed(s)) + a64;
			OP_LONG_HALF_MAC: r = longint'($signed(h1)) * longint'($signed(h2)) + a64;
			OP_LONG_DUAL_MAC: r = p1 + p2 + a64;
			OP_LONG_DUAL_SUB: r = p1 - p2 + a64;
			OP_WORD_HALF_MAC: begin
				r = longint'($signed(f)) * longint'($signed(h2)) + (av <<< 16);
				exp_set = (r >>> 16) != longint'($signed(r[47:16]));
				r = longint'(r[47:16]);
			end
			default: begin
				r = p1 - p2 + av;
				exp_set = r != longint'($signed(r[31:0]));
				r = longint'(r[31:0]);
			end
		endcase
		exp_hi = is_long ? r[63:32] : 32'h00000000;
		exp_lo = r[31:0];
	endfunction

	task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk1(input string name, input logic e, input logic g);
		chk32(name, {31'h0, e}, {31'h0, g});
	endtask

	// one instruction taken at the next edge, answer checked a half cycle later
	task automatic step();
		predict();
		valid = 1'b1;
		if (cond) sat_model = sat_model | exp_set;
		@(negedge clk);
		chk1("done", 1'b1, done);
		chk1("wr_high", cond & is_long, wr_hi);
		chk1("wr_low", cond, wr_lo);
		chk1("sat", sat_model, sat);
		if (cond) begin
			chk32("high", exp_hi, hi_out);
			chk32("low", exp_lo, lo_out);
		end
	endtask

	task automatic set_ops(input op_e o, input logic c, input logic [31:0] a, b, q, h, l);
		op = o;
		cond = c;
		f = a;
		s = b;
		acc = q;
		pa = h;
		pb = l;
	endtask

	// reset mid run: flag and strobes clear, next instruction may follow at once
	task automatic pulse_reset();
		valid = 1'b0;
		rst = 1'b1;
		@(negedge clk);
		chk1("reset sat", 1'b0, sat);
		chk1("reset done", 1'b0, done);
		rst = 1'b0;
		sat_model = 1'b0;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end

	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(negedge clk);
		chk32("reset low", 32'h0, lo_out);
		rst = 1'b0;
		// word by halfword overflow, first with failed condition
		set_ops(OP_WORD_HALF_MAC, 1'b0, 32'h7fffffff, 32'h00007fff, 32'h7fffffff, 0, 0);
		step();
		cond = 1'b1;
		step();
		// long wrap with flag already set
		set_ops(OP_LONG_MAC, 1'b1, 32'h7fffffff, 32'h7fffffff, 0, 32'h7fffffff, 32'hffffffff);
		step();
		// clock enable low freezes outputs
		ce = 1'b0;
		f = 32'h12345678;
		@(negedge clk);
		chk32("frozen low", exp_lo, lo_out);
		chk1("frozen done", 1'b1, done);
		ce = 1'b1;
		valid = 1'b0;
		@(negedge clk);
		chk1("idle done", 1'b0, done);
		// accumulate field all ones in dual subtract
		set_ops(OP_DUAL_SUB, 1'b1, 32'h80008000, 32'h7fff8000, 32'h7fffffff, 0, 0);
		raw_field = 4'hf;
		step();
		// random back to back instructions, flag cleared by a reset now and then
		for (int i = 0; i < 2000; i++) begin
			if (i % 100 == 0) pulse_reset();
			lfsr = lfsr_next(lfsr);
			{fh, sh, swap, raw_field} = lfsr[6:0];
			op = op_e'(3'(lfsr[15:8] % 6));
			cond = lfsr[17] | lfsr[18];
			lfsr = lfsr_next(lfsr);
			f = lfsr;
			lfsr = lfsr_next(lfsr);
			s = lfsr;
			lfsr = lfsr_next(lfsr);
			acc = lfsr;
			pa = lfsr ^ 32'h5a5a0ff0;
			pb = {lfsr[15:0], lfsr[31:16]};
			step();
		end
		// reset at the end of the run clears flag and done
		pulse_reset();
		end_sim();
	end
endmodule

`default_nettype wire
